// [verilog/small_ram_pkg.sv]
`default_nettype none
package small_ram_pkg;

   // ==========================================================
   // Array size and port widths
   localparam int ARRAY_BITS = 576;
   localparam int DATA_W     = 18;
   localparam int ADDR_W     = 9;
   localparam int COUNT_W    = 10;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] RDATA_OFFSET  = 12'h008;

   // Control fields
   localparam int CTRL_BYPASS_BIT = 0;
   localparam int CTRL_OLD_BIT    = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

   // Status fields
   localparam int STATUS_EMPTY_BIT = 0;
   localparam int STATUS_FULL_BIT  = 1;
   localparam int STATUS_COUNT_LSB = 16;

   // Value returned by a colliding read when old data is not selected
   localparam logic [DATA_W-1:0] UNDEFINED_WORD = 18'h3_ffff;

   // ==========================================================
   // Build-time modes and shapes
   typedef enum {MODE_SIMPLE_DUAL, MODE_SINGLE, MODE_FIFO, MODE_ROM, MODE_SHIFT} mode_type;
   typedef enum {SHAPE_512X1, SHAPE_256X2, SHAPE_128X4, SHAPE_64X8, SHAPE_64X9,
                 SHAPE_32X16, SHAPE_32X18} shape_type;

   typedef struct packed {
      logic              en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } write_req_type;

   typedef struct packed {
      logic              en;
      logic [ADDR_W-1:0] addr;
   } read_req_type;

   function automatic logic [4:0] shape_width(shape_type s);
      case (s)
         SHAPE_512X1: shape_width = 5'd1;
         SHAPE_256X2: shape_width = 5'd2;
         SHAPE_128X4: shape_width = 5'd4;
         SHAPE_64X8:  shape_width = 5'd8;
         SHAPE_64X9:  shape_width = 5'd9;
         SHAPE_32X16: shape_width = 5'd16;
         default:     shape_width = 5'd18;
      endcase
   endfunction

   function automatic logic [COUNT_W-1:0] shape_depth(shape_type s);
      case (s)
         SHAPE_512X1: shape_depth = 10'd512;
         SHAPE_256X2: shape_depth = 10'd256;
         SHAPE_128X4: shape_depth = 10'd128;
         SHAPE_64X8:  shape_depth = 10'd64;
         SHAPE_64X9:  shape_depth = 10'd64;
         default:     shape_depth = 10'd32;
      endcase
   endfunction

endpackage
`default_nettype wire

// [verilog/small_dual_port_ram_block.sv]
// Functional notes
// - One write port and one read port, usable together; no second read/write port.
// - Storage array holds 576 bits, parity bits included.
// - Build-time modes: simple dual-port, single-port, FIFO, ROM, shift register.
// - Shapes 512x1 256x2 128x4 64x8 64x9 32x16 32x18.
// - Write enable, data and address registers share one clock.
// - Read address, read enable and output registers use the same clock, pclk.
// - Only the output register is bypassable; input registers always present.
// - RAM or ROM contents load from an initial image before operation.
//
// Implementation choices: the register addresses and register access over APB.
`default_nettype none
module small_dual_port_ram_block
   import small_ram_pkg::*;
#(
   parameter mode_type               mode       = MODE_SIMPLE_DUAL,
   parameter shape_type              shape      = SHAPE_32X18,
   parameter logic [ARRAY_BITS-1:0]  init_image = '0
) (
   // APB
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // User ports
   input  wire write_req_type       wr,
   input  wire read_req_type        rd,
   input  wire logic                out_clear,
   output logic      [DATA_W-1:0]   rdata,
   output logic                     fifo_full,
   output logic                     fifo_empty
);

   localparam logic [4:0]         WIDTH = shape_width(shape);
   localparam logic [COUNT_W-1:0] DEPTH = shape_depth(shape);

   // ==========================================================
   // Array access helpers
   function automatic logic [DATA_W-1:0] read_word(logic [ARRAY_BITS-1:0] m,
                                                   logic [ADDR_W-1:0] a);
      logic [COUNT_W-1:0] base;
      // Widen before the product: word 31 of the widest shape starts past bit 511
      base = COUNT_W'(a) * COUNT_W'(WIDTH);
      read_word = '0;
      for (int i = 0; i < DATA_W; i++) begin
         if (i < WIDTH) begin
            read_word[i] = m[base + COUNT_W'(i)];
         end
      end
   endfunction

   function automatic logic [ARRAY_BITS-1:0] write_word(logic [ARRAY_BITS-1:0] m,
                                                        logic [ADDR_W-1:0] a,
                                                        logic [DATA_W-1:0] d);
      logic [COUNT_W-1:0] base;
      base = COUNT_W'(a) * COUNT_W'(WIDTH);
      write_word = m;
      for (int i = 0; i < DATA_W; i++) begin
         if (i < WIDTH) begin
            write_word[base + COUNT_W'(i)] = d[i];
         end
      end
   endfunction

   function automatic logic [ADDR_W-1:0] wrap(logic [ADDR_W-1:0] p);
      wrap = ({1'b0, p} + 10'd1 == DEPTH) ? '0 : p + 9'd1;
   endfunction

   // ==========================================================
   // State
   logic [ARRAY_BITS-1:0] mem, next_mem;
   write_req_type         wr_q, next_wr_q;
   read_req_type          rd_q, next_rd_q;
   logic [ADDR_W-1:0]     wptr, next_wptr, rptr, next_rptr;
   logic [COUNT_W-1:0]    count, next_count;
   logic [DATA_W-1:0]     out_reg, next_out_reg;
   logic [DATA_W-1:0]     word, next_rdata;
   logic                  next_fifo_full, next_fifo_empty;
   logic [31:0]           ctrl, next_ctrl, next_prdata;
   logic                  next_pslverr;
   logic [ADDR_W-1:0]     waddr_eff, raddr_eff;
   logic                  do_write, do_read, bypass, old_data;

   assign bypass   = ctrl[CTRL_BYPASS_BIT];
   assign old_data = ctrl[CTRL_OLD_BIT];

   // ==========================================================
   // Input registers, always present; one clock for both ports
   always_comb begin
      next_wr_q = wr;
      next_rd_q = rd;
      if (mode == MODE_SINGLE) begin
         next_rd_q.addr = wr.addr;
      end
   end

   // ==========================================================
   // Array, pointers and read path
   always_comb begin
      waddr_eff  = wr_q.addr;
      raddr_eff  = rd_q.addr;
      do_write   = wr_q.en;
      do_read    = rd_q.en;
      next_wptr  = wptr;
      next_rptr  = rptr;
      next_count = count;
      case (mode)
         MODE_FIFO: begin
            waddr_eff = wptr;
            raddr_eff = rptr;
            do_write  = wr_q.en && count != DEPTH;
            do_read   = rd_q.en && count != '0;
            if (do_write) begin
               next_wptr = wrap(wptr);
            end
            if (do_read) begin
               next_rptr = wrap(rptr);
            end
            next_count = count + COUNT_W'(do_write) - COUNT_W'(do_read);
         end
         MODE_SHIFT: begin
            // Oldest tap is read out as the newest word overwrites it
            waddr_eff = wptr;
            raddr_eff = wptr;
            do_read   = wr_q.en;
            if (wr_q.en) begin
               next_wptr = wrap(wptr);
            end
         end
         MODE_ROM: begin
            do_write = 1'b0;
         end
         default: begin
         end
      endcase
      next_mem = do_write ? write_word(mem, waddr_eff, wr_q.data) : mem;
      word     = read_word(mem, raddr_eff);
      if (do_read && do_write && raddr_eff == waddr_eff && !old_data &&
          mode != MODE_SHIFT) begin
         word = UNDEFINED_WORD;
      end
      next_out_reg    = do_read ? word : out_reg;
      next_rdata      = bypass ? (do_read ? word : rdata) : out_reg;
      next_fifo_full  = next_count == DEPTH;
      next_fifo_empty = next_count == '0;
   end

   // ==========================================================
   // APB slave: zero wait states, decode in setup phase
   always_comb begin
      next_ctrl    = ctrl;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            CTRL_OFFSET:   next_prdata = ctrl;
            STATUS_OFFSET: next_prdata = {6'h00, count, 14'h0000, fifo_full, fifo_empty};
            RDATA_OFFSET:  next_prdata = {14'h0000, rdata};
            default: begin
               next_prdata  = 32'h0000_0000;
               next_pslverr = 1'b1;
            end
         endcase
      end else if (psel && penable) begin
         next_pslverr = pslverr;
         if (pwrite && paddr == CTRL_OFFSET) begin
            next_ctrl = {30'h0000_0000, pwdata[1:0]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem        <= init_image;
         wr_q       <= '0;
         rd_q       <= '0;
         wptr       <= '0;
         rptr       <= '0;
         count      <= '0;
         fifo_full  <= 1'b0;
         fifo_empty <= 1'b1;
         ctrl       <= CTRL_RESET;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else begin
         mem        <= next_mem;
         wr_q       <= next_wr_q;
         rd_q       <= next_rd_q;
         wptr       <= next_wptr;
         rptr       <= next_rptr;
         count      <= next_count;
         fifo_full  <= next_fifo_full;
         fifo_empty <= next_fifo_empty;
         ctrl       <= next_ctrl;
         prdata     <= next_prdata;
         pready     <= 1'b1;
         pslverr    <= next_pslverr;
      end
   end

   // Output clear is asynchronous and touches nothing else
   always_ff @(posedge pclk or negedge presetn or posedge out_clear) begin
      if (!presetn || out_clear) begin
         out_reg <= '0;
         rdata   <= '0;
      end else begin
         out_reg <= next_out_reg;
         rdata   <= next_rdata;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fifo_bound: assert property (count <= DEPTH)
      else $error("fifo count above depth");
   a_full_flag: assert property (fifo_full == (count == DEPTH))
      else $error("full flag disagrees with count");
   a_rom_frozen: assert property (mode == MODE_ROM |-> $stable(mem))
      else $error("rom contents changed");
   a_write_lands: assert property (
      mode == MODE_SIMPLE_DUAL && wr.en |=> ##1 read_word(mem, $past(wr.addr, 2)) ==
      ($past(wr.data, 2) & DATA_W'((1 << WIDTH) - 1)))
      else $error("write did not land two edges later");
   a_reg_latency: assert property (
      !bypass && !out_clear && $past(!bypass) && mode == MODE_SIMPLE_DUAL && rd_q.en
      ##1 !out_clear ##1 !out_clear |-> rdata == $past(out_reg))
      else $error("output register stage missing");
   a_clear_only_out: assert property (out_clear && !do_write |=> $stable(mem))
      else $error("output clear disturbed the array");
   a_old_data: assert property (
      old_data && mode == MODE_SIMPLE_DUAL && do_read && do_write && raddr_eff == waddr_eff
      |=> out_reg == $past(read_word(mem, raddr_eff)))
      else $error("collision did not return old data");
   a_in_regs: assert property (
      rd_q.addr == $past(mode == MODE_SINGLE ? wr.addr : rd.addr))
      else $error("read address register bypassed");
   a_pready_up: assert property (presetn && $past(presetn) |-> pready)
      else $error("slave not ready after reset");

   c_fifo_full:   cover property (fifo_full);
   c_collision:   cover property (do_read && do_write && raddr_eff == waddr_eff);
   c_bypass_read: cover property (bypass && do_read);
   c_out_clear:   cover property (out_clear && $past(rdata) != '0);

endmodule // small_dual_port_ram_block
`default_nettype wire

// [verilog/README_unused.sv]
`default_nettype none
`default_nettype wire

// [tb/user_logic_model.sv]
`default_nettype none
module user_logic_model
   import small_ram_pkg::*;
(
   // Clock
   input  wire logic     pclk,
   // Requests toward the block
   output var write_req_type wr,
   output var read_req_type  rd
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      wr = '0;
      rd = '0;
   end

   // =========================================================
   // Fabric logic request: one cycle, then scrambled lines so a stale value never looks valid
   task automatic op(input logic we, input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] wd,
                     input logic re, input logic [ADDR_W-1:0] ra);
      @(posedge pclk);
      wr <= '{we, wa, wd};
      rd <= '{re, ra};
      @(posedge pclk);
      wr <= '{1'b0, ~wa, ~wd};
      rd <= '{1'b0, ~ra};
   endtask
endmodule // user_logic_model
`default_nettype wire

// [tb/tb_small_dual_port_ram_block.sv]
`default_nettype none
module tb_small_dual_port_ram_block import small_ram_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   // =========================================================
   // Signals
   logic              pclk, presetn, psel, penable, pwrite, out_clear, pready, pslverr;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata;
   write_req_type     wr;
   read_req_type      rd;
   logic [DATA_W-1:0] rdata, d;
   logic              fifo_full, fifo_empty;
   int                fail_count = 0;
   int                comparisons = 0;
   logic [DATA_W-1:0] mem [32];
   logic [DATA_W-1:0] rq [$];
   logic [32:0]       aq [$];
   logic [2:0]        rpipe = 3'h0;
   logic              byp = 1'b0;
   logic [31:0]       seed = 32'h0000_001a;
   write_req_type     fifo_wr = '0;
   read_req_type      fifo_rd = '0;
   logic [DATA_W-1:0] fifo_rdata;
   logic              fifo_is_full, fifo_is_empty;
   logic [DATA_W-1:0] fq [$];
   logic [2:0]        fpipe = 3'h0;

   function automatic logic [DATA_W-1:0] img_word(int i);
      return DATA_W'(i * 37 + 5);
   endfunction
   function automatic logic [ARRAY_BITS-1:0] mk_img();
      mk_img = '0;
      for (int i = 0; i < 32; i++) mk_img[i*DATA_W +: DATA_W] = img_word(i);
   endfunction
   localparam logic [ARRAY_BITS-1:0] IMG = mk_img();

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   small_dual_port_ram_block #(.mode(MODE_SIMPLE_DUAL), .shape(SHAPE_32X18), .init_image(IMG))
      small_dual_port_ram_block_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wr(wr), .rd(rd), .out_clear(out_clear),
      .rdata(rdata), .fifo_full(fifo_full), .fifo_empty(fifo_empty));
   user_logic_model user_logic_model_inst (.pclk(pclk), .wr(wr), .rd(rd));
   small_dual_port_ram_block #(.mode(MODE_FIFO), .shape(SHAPE_32X18), .init_image('0))
      fifo_small_dual_port_ram_block_inst (.pclk(pclk), .presetn(presetn), .psel(1'b0),
      .penable(1'b0), .pwrite(1'b0), .paddr(12'h000), .pwdata(32'h0000_0000), .prdata(),
      .pready(), .pslverr(), .wr(fifo_wr), .rd(fifo_rd), .out_clear(out_clear),
      .rdata(fifo_rdata), .fifo_full(fifo_is_full), .fifo_empty(fifo_is_empty));

   // =========================================================
   // Checking
   task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task stop_test();
      if (fail_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Read results land a fixed number of edges after the request
   always @(posedge pclk) begin
      rpipe <= {rpipe[1:0], rd.en};
      fpipe <= {fpipe[1:0], fifo_rd.en};
      if (psel && penable && pready && !pwrite) begin
         if (aq.size() == 0) check("apb unexpected", 33'h0_0000_0000, {pslverr, prdata});
         else check("apb read", aq.pop_front(), {pslverr, prdata});
      end
   end
   always @(negedge pclk) begin
      if (byp ? rpipe[1] : rpipe[2]) begin
         if (rq.size() == 0) check("rdata unexpected", 33'h0_0000_0000, 33'h1_0000_0000);
         else check("rdata", 33'(rq.pop_front()), 33'(rdata));
      end
      if (fpipe[2]) begin
         if (fq.size() == 0) check("fifo rdata unexpected", 33'h0_0000_0000, 33'h1_0000_0000);
         else check("fifo rdata", 33'(fq.pop_front()), 33'(fifo_rdata));
      end
   end

   // =========================================================
   // Stimulus
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      input logic [32:0] exp);
      if (!w) aq.push_back(exp);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      stop_test();
   end

   initial begin
      {psel, penable, pwrite, out_clear, presetn} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      for (int i = 0; i < 32; i++) mem[i] = img_word(i);
      repeat (4) @(posedge pclk);
      check("rdata in reset", 33'h0_0000_0000, 33'(rdata));
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFFSET, 32'h0000_0000, {1'b0, CTRL_RESET});
      apb(1'b0, 12'h00c, 32'h0000_0000, 33'h1_0000_0000);
      apb(1'b0, STATUS_OFFSET, 32'h0000_0000, 33'h0_0000_0001);
      check("fifo flags idle", 33'h0_0000_0001, 33'({fifo_full, fifo_empty}));
      // Whole array: image first, then random contents over every word
      for (int i = 0; i < 32; i++) begin
         rq.push_back(mem[i]);
         user_logic_model_inst.op(1'b0, 9'h000, '0, 1'b1, 9'(i));
      end
      for (int i = 0; i < 32; i++) begin
         mem[i] = DATA_W'(xs());
         user_logic_model_inst.op(1'b1, 9'(i), mem[i], 1'b0, 9'h000);
      end
      for (int i = 0; i < 32; i++) begin
         rq.push_back(mem[i]);
         user_logic_model_inst.op(1'b0, 9'h000, '0, 1'b1, 9'(i));
      end
      // Collisions: old data at reset setting, then the undefined word
      d = DATA_W'(xs());
      rq.push_back(mem[5]);
      user_logic_model_inst.op(1'b1, 9'h005, d, 1'b1, 9'h005);
      mem[5] = d;
      repeat (4) @(posedge pclk);
      apb(1'b1, CTRL_OFFSET, 32'h0000_0000, '0);
      d = DATA_W'(xs());
      rq.push_back(UNDEFINED_WORD);
      user_logic_model_inst.op(1'b1, 9'h006, d, 1'b1, 9'h006);
      mem[6] = d;
      rq.push_back(mem[6]);
      user_logic_model_inst.op(1'b0, 9'h000, '0, 1'b1, 9'h006);
      // Bypassed output register, both ports busy together
      repeat (4) @(posedge pclk);
      apb(1'b1, CTRL_OFFSET, 32'h0000_0001, '0);
      byp = 1'b1;
      d = DATA_W'(xs());
      rq.push_back(mem[9]);
      user_logic_model_inst.op(1'b1, 9'h00a, d, 1'b1, 9'h009);
      mem[10] = d;
      rq.push_back(mem[10]);
      user_logic_model_inst.op(1'b0, 9'h000, '0, 1'b1, 9'h00a);
      repeat (4) @(posedge pclk);
      apb(1'b1, CTRL_OFFSET, 32'h0000_0002, '0);
      byp = 1'b0;
      // Output clear hits only the output register
      rq.push_back(mem[3]);
      user_logic_model_inst.op(1'b0, 9'h000, '0, 1'b1, 9'h003);
      repeat (4) @(posedge pclk);
      apb(1'b0, RDATA_OFFSET, 32'h0000_0000, 33'(mem[3]));
      out_clear <= 1'b1;
      @(negedge pclk);
      check("rdata after clear", 33'h0_0000_0000, 33'(rdata));
      @(posedge pclk);
      out_clear <= 1'b0;
      rq.push_back(mem[3]);
      user_logic_model_inst.op(1'b0, 9'h000, '0, 1'b1, 9'h003);
      // FIFO mode: fill past full (last push dropped), then drain in order
      for (int i = 0; i < 33; i++) begin
         @(posedge pclk);
         d = DATA_W'(xs());
         if (i < 32) fq.push_back(d);
         fifo_wr <= '{1'b1, 9'h000, d};
      end
      @(posedge pclk);
      fifo_wr <= '0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check("fifo flags full", 33'h0_0000_0002, 33'({fifo_is_full, fifo_is_empty}));
      for (int i = 0; i < 32; i++) begin
         @(posedge pclk);
         fifo_rd <= '{1'b1, 9'h000};
      end
      @(posedge pclk);
      fifo_rd <= '0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      check("fifo flags empty", 33'h0_0000_0001, 33'({fifo_is_full, fifo_is_empty}));
      repeat (5) @(posedge pclk);
      stop_test();
   end
endmodule // tb_small_dual_port_ram_block
`default_nettype wire
